// ===== design/dram_ctrl_end.sv
// Controller end: spaces commands with down-counters
module dram_ctrl_end
	import dram_timing_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	dram_timing_if.ctrl link,
	input wire logic req_valid,
	input cmd_t req_cmd,
	input wire logic [MODE_W-1:0] req_mode,
	input wire logic req_cke,
	input wire logic req_odt,
	input wire logic req_fast,
	input wire logic req_wbad,
	output logic req_ready,
	output logic odt_active
);
	typedef struct packed {
		logic [CNT_W-1:0] act_cnt;
		logic [CNT_W-1:0] rd_cnt;
		logic [CNT_W-1:0] cke_cnt;
		logic [WR_W-1:0] wr;
		logic cmd_valid;
		cmd_t cmd;
		logic [MODE_W-1:0] mode;
		logic wlast;
		logic wbad;
		logic cke;
		logic odt;
		logic fast;
		logic odt_seen;
		logic ready;
	} ctrl_state_t;
	ctrl_state_t st_reg, st_next;
	logic ok;

	always_comb begin
		st_next = st_reg;
		st_next.cmd_valid = 1'b0;
		st_next.wlast = 1'b0;
		st_next.wbad = 1'b0;
		st_next.odt = req_odt;
		st_next.fast = req_fast;
		st_next.odt_seen = link.odt_on;
		if (st_reg.act_cnt != CNT_ZERO) st_next.act_cnt = st_reg.act_cnt - CNT_ONE;
		if (st_reg.rd_cnt != CNT_ZERO) st_next.rd_cnt = st_reg.rd_cnt - CNT_ONE;
		if (st_reg.cke_cnt != CNT_ZERO) st_next.cke_cnt = st_reg.cke_cnt - CNT_ONE;
		if (req_cke != st_reg.cke && st_reg.cke_cnt == CNT_ZERO) begin
			st_next.cke = req_cke;
			st_next.cke_cnt = CNT_W'(CKE_REG_CYC);
		end
		ok = 1'b1;
		if (req_cmd == CMD_ACT && st_reg.act_cnt > CNT_ONE) ok = 1'b0;
		if (req_cmd == CMD_READ && st_reg.rd_cnt > CNT_ONE) ok = 1'b0;
		if (req_valid && ok) begin
			st_next.cmd_valid = 1'b1;
			st_next.cmd = req_cmd;
			st_next.mode = req_mode;
			unique case (req_cmd)
				CMD_WRITE_AP, CMD_WRITE: begin
					st_next.wlast = 1'b1;
					st_next.wbad = req_wbad;
					st_next.rd_cnt = CNT_W'(WRITE_TO_READ_CYC + 1);
					if (req_cmd == CMD_WRITE_AP)
						st_next.act_cnt = CNT_W'(st_reg.wr) + CNT_W'(PRECHARGE_CYC + 1);
				end
				CMD_PD_EXIT: st_next.act_cnt = CNT_W'(PD_EXIT_CYC + 1);
				CMD_MODE: st_next.wr = req_mode[WR_W-1:0];
				default: ;
			endcase
		end
		// Registered copy of the spacing state for the request side
		st_next.ready = (st_next.act_cnt <= CNT_ONE) && (st_next.rd_cnt <= CNT_ONE);
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	assign req_ready = st_reg.ready;
	assign odt_active = st_reg.odt_seen;
	assign link.cmd_valid = st_reg.cmd_valid;
	assign link.cmd = st_reg.cmd;
	assign link.mode_word = st_reg.mode;
	assign link.wdata_last = st_reg.wlast;
	assign link.wdata_bad = st_reg.wbad;
	assign link.cke = st_reg.cke;
	assign link.odt = st_reg.odt;
	assign link.fast_grade = st_reg.fast;
	assign link.freq_change = 1'b0;
endmodule : dram_ctrl_end

// ===== design/dram_device_end.sv
// Device end: timing checks, termination delay and strobe mode
// Notes on behaviour
// - Write autoprecharge to activate: WR plus tRP cycles
// - Clock change only in self-refresh or power-down
// - Fast grade termination on two cycles later
// - Slow grade termination on ten ns later
// - Fast grade termination off after two-and-half cycles
// - Slow grade termination off after two-and-half cycles
// - Mode bit ten selects strobe style
// - Wait two cycles after write before read
// - Clock enable held three edges
// - Bad write data rewritten before valid read
// - Nanosecond limits rounded up to cycles
// - Activate allowed two edges after power-down exit
module dram_device_end
	import dram_timing_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	dram_timing_if.dev link,
	output logic [WR_W-1:0] write_recovery,
	output logic data_suspect
);
	typedef struct packed {
		logic [CNT_W-1:0] act_cnt;
		logic [CNT_W-1:0] rd_cnt;
		logic [CNT_W-1:0] cke_cnt;
		logic [CNT_W-1:0] on_cnt;
		logic [CNT_W-1:0] off_cnt;
		logic cke_prev;
		logic odt_prev;
		logic powered_down;
		logic odt_on;
		logic strobe_diff;
		logic cmd_error;
		logic [WR_W-1:0] wr;
		logic suspect;
	} dev_state_t;
	dev_state_t st_reg, st_next;
	logic [CNT_W-1:0] on_delay, off_delay;

	always_comb begin
		on_delay = link.fast_grade ? CNT_W'(ODT_ON_FAST_CYC) : CNT_W'(ODT_ON_SLOW_CYC);
		off_delay = link.fast_grade ? CNT_W'(ODT_OFF_FAST_CYC) : CNT_W'(ODT_OFF_SLOW_CYC);
		st_next = st_reg;
		st_next.cmd_error = 1'b0;
		if (st_reg.act_cnt != CNT_ZERO) st_next.act_cnt = st_reg.act_cnt - CNT_ONE;
		if (st_reg.rd_cnt != CNT_ZERO) st_next.rd_cnt = st_reg.rd_cnt - CNT_ONE;
		if (st_reg.cke_cnt != CNT_ZERO) st_next.cke_cnt = st_reg.cke_cnt - CNT_ONE;
		// CKE registration window
		st_next.cke_prev = link.cke;
		if (link.cke != st_reg.cke_prev) begin
			if (st_reg.cke_cnt != CNT_ZERO) st_next.cmd_error = 1'b1;
			st_next.cke_cnt = CNT_W'(CKE_REG_CYC - 1);
			st_next.powered_down = ~link.cke;
		end
		if (link.freq_change && !st_reg.powered_down) st_next.cmd_error = 1'b1;
		if (link.wdata_bad) st_next.suspect = 1'b1;
		if (link.wdata_last) st_next.rd_cnt = CNT_W'(WRITE_TO_READ_CYC);
		if (link.cmd_valid) begin
			unique case (link.cmd)
				CMD_NOP: ;
				CMD_ACT: if (st_reg.act_cnt != CNT_ZERO) st_next.cmd_error = 1'b1;
				CMD_WRITE_AP: begin
					st_next.act_cnt = CNT_W'(st_reg.wr) + CNT_W'(PRECHARGE_CYC);
					st_next.suspect = link.wdata_bad;
				end
				CMD_WRITE: st_next.suspect = link.wdata_bad;
				CMD_READ: if (st_reg.rd_cnt != CNT_ZERO) st_next.cmd_error = 1'b1;
				CMD_PD_EXIT: st_next.act_cnt = CNT_W'(PD_EXIT_CYC);
				CMD_MODE: begin
					st_next.strobe_diff = ~link.mode_word[STROBE_SEL_BIT];
					st_next.wr = link.mode_word[WR_W-1:0];
				end
			endcase
		end
		// Termination delays
		st_next.odt_prev = link.odt;
		if (link.odt && !st_reg.odt_prev) st_next.on_cnt = on_delay;
		else if (st_reg.on_cnt != CNT_ZERO) begin
			st_next.on_cnt = st_reg.on_cnt - CNT_ONE;
			if (st_reg.on_cnt == CNT_ONE) st_next.odt_on = 1'b1;
		end
		if (!link.odt && st_reg.odt_prev) st_next.off_cnt = off_delay;
		else if (st_reg.off_cnt != CNT_ZERO) begin
			st_next.off_cnt = st_reg.off_cnt - CNT_ONE;
			if (st_reg.off_cnt == CNT_ONE) st_next.odt_on = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_reg <= '0;
			st_reg.strobe_diff <= 1'b1;
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	assign link.odt_on = st_reg.odt_on;
	assign link.strobe_diff = st_reg.strobe_diff;
	assign link.cmd_error = st_reg.cmd_error;
	assign write_recovery = st_reg.wr;
	assign data_suspect = st_reg.suspect;
endmodule : dram_device_end

// ===== design/dram_timing_if.sv
// Command link between controller and device ends
interface dram_timing_if;
	import dram_timing_pkg::*;
	logic cmd_valid;
	cmd_t cmd;
	logic [12:0] mode_word;
	logic wdata_last;
	logic cke;
	logic odt;
	logic fast_grade;
	logic freq_change;
	logic wdata_bad;
	logic cmd_error;
	logic odt_on;
	logic strobe_diff;
	modport ctrl (output cmd_valid, cmd, mode_word, wdata_last, cke, odt, fast_grade,
		freq_change, wdata_bad, input cmd_error, odt_on, strobe_diff);
	modport dev (input cmd_valid, cmd, mode_word, wdata_last, cke, odt, fast_grade,
		freq_change, wdata_bad, output cmd_error, odt_on, strobe_diff);
endinterface : dram_timing_if

// ===== design/dram_timing_pkg.sv
// Shared constants and types for the DRAM timing ends
package dram_timing_pkg;
	localparam int CLK_PERIOD_PS = 10000;
	localparam int PRECHARGE_PS = 15000;
	localparam int PRECHARGE_CYC = (PRECHARGE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WRITE_TO_READ_CYC = 2;
	localparam int CKE_REG_CYC = 3;
	localparam int PD_EXIT_CYC = 2;
	localparam int ODT_ON_FAST_CYC = 2;
	localparam int ODT_ON_SLOW_PS = 10000;
	localparam int ODT_ON_SLOW_CYC = (ODT_ON_SLOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int ODT_OFF_FAST_HALF = 5;
	localparam int ODT_OFF_SLOW_HALF = 5;
	localparam int ODT_OFF_FAST_CYC = (ODT_OFF_FAST_HALF + 1) / 2;
	localparam int ODT_OFF_SLOW_CYC = (ODT_OFF_SLOW_HALF + 1) / 2;
	localparam int STROBE_SEL_BIT = 10;
	localparam int MODE_W = 13;
	localparam int WR_W = 3;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	typedef enum logic [2:0] {
		CMD_NOP,
		CMD_ACT,
		CMD_WRITE_AP,
		CMD_WRITE,
		CMD_READ,
		CMD_PD_EXIT,
		CMD_MODE
	} cmd_t;
endpackage : dram_timing_pkg

// ===== sim/dram_timing_asserts.sv
// Link timing assertions
module dram_timing_asserts
	import dram_timing_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic cmd_valid,
	input cmd_t cmd,
	input wire logic [12:0] mode_word,
	input wire logic wdata_last,
	input wire logic cke,
	input wire logic odt,
	input wire logic cmd_error,
	input wire logic odt_on,
	input wire logic strobe_diff
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [WR_W-1:0] wr_reg;
	logic [CNT_W-1:0] gap_reg;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	// Mirror of recovery value and activate spacing
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wr_reg <= 3'h0;
			gap_reg <= CNT_ZERO;
		end else begin
			if (cmd_valid && cmd == CMD_MODE) begin
				wr_reg <= mode_word[2:0];
			end
			if (cmd_valid && cmd == CMD_WRITE_AP) begin
				gap_reg <= CNT_W'(wr_reg) + CNT_W'(PRECHARGE_CYC) - CNT_ONE;
			end else if (gap_reg != CNT_ZERO) begin
				gap_reg <= gap_reg - CNT_ONE;
			end
		end
	end
	a_dal_gap: assert property (cmd_valid && cmd == CMD_ACT |-> gap_reg == CNT_ZERO)
		else $error("activate too early");
	a_cke_hold: assert property ($changed(cke) |=> $stable(cke) [*2])
		else $error("cke changed early");
	a_wtr_gap: assert property (cmd_valid && wdata_last |=> !(cmd_valid && cmd == CMD_READ))
		else $error("read too early");
	a_pd_exit_gap: assert property (cmd_valid && cmd == CMD_PD_EXIT |=> cmd != CMD_ACT)
		else $error("activate after exit");
	a_strobe_select: assert property (cmd_valid && cmd == CMD_MODE |=>
		strobe_diff == !$past(mode_word[STROBE_SEL_BIT])) else $error("strobe mode");
	a_odt_on_late: assert property ($rose(odt) ##1 odt [*4] |-> odt_on)
		else $error("termination on late");
	a_odt_off_late: assert property ($fell(odt) ##1 !odt [*5] |-> !odt_on)
		else $error("termination off late");
	a_no_cmd_error: assert property (!cmd_error)
		else $error("command error");
endmodule : dram_timing_asserts

// ===== sim/test_sdram_timing_constraints.sv
// Bench joining controller and device ends
module test_sdram_timing_constraints
	import dram_timing_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'h0, sys_rst = 1'h1, clk_en = 1'h1, req_valid = 1'h0, req_cke = 1'h0;
	logic req_odt = 1'h0, req_fast = 1'h0, req_wbad = 1'h0, req_ready, odt_active, data_suspect;
	cmd_t req_cmd = CMD_NOP;
	logic [MODE_W-1:0] req_mode = 13'h0000;
	logic [WR_W-1:0] write_recovery;
	int miscompares = 0, checked = 0, cyc = 0, last_cyc = 0, gap = 0;
	dram_timing_if link ();
	dram_ctrl_end dram_ctrl_end_inst (.ref_clk, .sys_rst, .clk_en, .link(link.ctrl), .req_valid,
		.req_cmd, .req_mode, .req_cke, .req_odt, .req_fast, .req_wbad, .req_ready, .odt_active);
	dram_device_end dram_device_end_inst (.ref_clk, .sys_rst, .clk_en, .link(link.dev),
		.write_recovery, .data_suspect);
	dram_timing_asserts dram_timing_asserts_inst (.ref_clk, .sys_rst, .cmd_valid(link.cmd_valid),
		.cmd(link.cmd), .mode_word(link.mode_word), .wdata_last(link.wdata_last), .cke(link.cke),
		.odt(link.odt), .cmd_error(link.cmd_error), .odt_on(link.odt_on),
		.strobe_diff(link.strobe_diff));
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	// Cycles between commands on the link
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (link.cmd_valid === 1'h1) begin
			gap <= cyc - last_cyc;
			last_cyc <= cyc;
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	task automatic idle(input int k);
		req_valid = 1'h0;
		repeat (k) @(negedge ref_clk);
	endtask : idle
	task automatic issue(input cmd_t c, input logic [MODE_W-1:0] m);
		int n;
		n = 0;
		req_cmd = c;
		req_mode = m;
		req_valid = 1'h1;
		while (req_ready !== 1'h1 && (c == CMD_ACT || c == CMD_READ) && n < 50) begin
			@(negedge ref_clk);
			n++;
		end
		@(negedge ref_clk);
	endtask : issue
	task automatic pair(input cmd_t a, input cmd_t b, input int exp);
		issue(a, 13'h0003);
		issue(b, 13'h0003);
		idle(2);
		chk(8'(gap >= exp), 8'h01);
	endtask : pair
	task automatic complete_run();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run
	initial begin
		#50000;
		miscompares++;
		complete_run();
	end
	initial begin
		repeat (16) @(negedge ref_clk);
		sys_rst = 1'h0;
		req_cke = 1'h1;
		idle(1);
		chk(8'(link.strobe_diff), 8'h01);
		issue(CMD_MODE, 13'h0403);
		idle(2);
		chk(8'(link.strobe_diff), 8'h00);
		chk(8'(write_recovery), 8'h03);
		issue(CMD_MODE, 13'h0003);
		idle(2);
		chk(8'(link.strobe_diff), 8'h01);
		$display("test mode done");
		pair(CMD_WRITE_AP, CMD_ACT, 3 + PRECHARGE_CYC);
		pair(CMD_WRITE, CMD_READ, WRITE_TO_READ_CYC);
		req_cke = 1'h0;
		idle(1);
		req_cke = 1'h1;
		idle(6);
		chk(8'(link.cke), 8'h01);
		pair(CMD_PD_EXIT, CMD_ACT, PD_EXIT_CYC);
		$display("test spacing done");
		for (int f = 0; f < 2; f++) begin
			req_fast = 1'(f);
			req_odt = 1'h1;
			idle(2);
			chk(8'(link.odt_on), 8'h00);
			idle(4);
			chk(8'(link.odt_on), 8'h01);
			req_odt = 1'h0;
			idle(2);
			chk(8'(link.odt_on), 8'h01);
			idle(6);
			chk(8'(odt_active), 8'h00);
		end
		$display("test termination done");
		clk_en = 1'h0;
		issue(CMD_MODE, 13'h0403);
		idle(3);
		chk(8'(link.strobe_diff), 8'h01);
		clk_en = 1'h1;
		idle(3);
		chk(8'(link.strobe_diff), 8'h01);
		$display("test clock enable done");
		req_wbad = 1'h1;
		issue(CMD_WRITE, 13'h0003);
		req_wbad = 1'h0;
		idle(2);
		chk(8'(data_suspect), 8'h01);
		issue(CMD_WRITE, 13'h0003);
		idle(2);
		chk(8'(data_suspect), 8'h00);
		$display("test rewrite done");
		complete_run();
	end
endmodule : test_sdram_timing_constraints
